// *** core/dtp_pkg.sv ***
// Constants, register map and carrier types for the dual timer/PWM block
package dtp_pkg;

	// ======================================================================
	// Register indices (byte address is four times the index)
	// ======================================================================
	localparam logic [7:0] IDX_TIMER_PWM_AND_WIDTH_CONTROL   = 8'h91;
	localparam logic [7:0] IDX_MODE    = 8'h80;
	localparam logic [7:0] IDX_CTRL    = 8'h81;
	localparam logic [7:0] IDX_TL0     = 8'h82;
	localparam logic [7:0] IDX_TH0     = 8'h83;
	localparam logic [7:0] IDX_TL1     = 8'h84;
	localparam logic [7:0] IDX_TH1     = 8'h85;
	localparam logic [7:0] IDX_RL0     = 8'h86;
	localparam logic [7:0] IDX_RH0     = 8'h87;
	localparam logic [7:0] IDX_RL1     = 8'h88;
	localparam logic [7:0] IDX_RH1     = 8'h89;
	localparam logic [7:0] IDX_CLKCTL  = 8'h8a;
	localparam logic [7:0] IDX_TPS     = 8'h8b;

	// ======================================================================
	// Reset values
	// ======================================================================
	localparam logic [7:0] TIMER_PWM_AND_WIDTH_CONTROL_RST   = 8'h24;
	localparam logic [7:0] ZERO_RST    = 8'h00;

	// ======================================================================
	// Field positions
	// ======================================================================
	localparam int T1_PWM_BIT  = 7;
	localparam int T0_PWM_BIT  = 6;
	localparam int T1_WIDTH_SEL_LSB    = 3;
	localparam int T0_WIDTH_SEL_LSB    = 0;
	localparam int TIMER1_GATING_ON_BIT   = 7;
	localparam int CT1_BIT     = 6;
	localparam int M1_LSB      = 4;
	localparam int TIMER0_GATING_ON_BIT   = 3;
	localparam int CT0_BIT     = 2;
	localparam int M0_LSB      = 0;
	localparam int TF1_BIT     = 7;
	localparam int TR1_BIT     = 6;
	localparam int TF0_BIT     = 5;
	localparam int TR0_BIT     = 4;
	localparam int X2_0_BIT    = 0;
	localparam int X2_1_BIT    = 1;
	localparam int FAST_BIT    = 7;

	// ======================================================================
	// Types
	// ======================================================================
	typedef enum logic [1:0] {
		MODE_VAR_WIDTH,
		MODE_AUTO16,
		MODE_AUTO8,
		MODE_SPLIT
	} dtp_mode_e;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} dtp_cnt_s;

	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] hi;
		logic       ovf;
		logic       hi_adv;
		logic       hi_wrap;
		logic       lo_wrap;
	} dtp_step_s;

endpackage

// *** core/dtp_timers.sv ***
// Two timer/counters with PWM outputs behind an AHB-Lite register slave
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps

module dtp_timers
	import dtp_pkg::*;
#(
	parameter int TPS_W = 4
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        ext_gate_pin_a,
	input  wire logic        ext_gate_pin_b,
	input  wire logic        timer0_pin_in,
	output logic             timer0_pin_out,
	output logic             timer0_pin_oe,
	input  wire logic        timer1_pin_in,
	output logic             timer1_pin_out,
	output logic             timer1_pin_oe
);

	// ======================================================================
	// Functions
	// ======================================================================
	// One count step of a non-split timer
	function automatic dtp_step_s step(input logic [7:0] lo, input logic [7:0] hi,
		input logic [7:0] rl, input logic [7:0] rh, input dtp_mode_e md,
		input logic [2:0] psc, input logic pwm, input logic pulse);
		logic [7:0] mask;
		dtp_step_s  s;
		mask = 8'hff >> (3'd7 - psc);
		s = '{lo: lo, hi: hi, ovf: 1'b0, hi_adv: 1'b0, hi_wrap: 1'b0,
			lo_wrap: 1'b0};
		if (pulse) begin
			case (md)
				MODE_VAR_WIDTH: begin
					// Upper low bits are left alone, they carry no meaning
					s.lo = (lo & ~mask) | ((lo + 8'h01) & mask);
					if ((lo & mask) == mask) begin
						s.hi = hi + 8'h01;
						s.hi_adv = 1'b1;
						s.hi_wrap = (hi == 8'hff);
						s.ovf = (hi == 8'hff);
					end
				end
				MODE_AUTO16: begin
					if (pwm) begin
						s.lo = (lo == 8'hff) ? rl : lo + 8'h01;
						if (lo == 8'hff) begin
							s.hi = hi + 8'h01;
							s.hi_adv = 1'b1;
							s.hi_wrap = (hi == 8'hff);
							s.ovf = (hi == 8'hff);
						end
					end else if ({hi, lo} == 16'hffff) begin
						s.hi = rh;
						s.lo = rl;
						s.ovf = 1'b1;
					end else begin
						{s.hi, s.lo} = {hi, lo} + 16'h0001;
					end
				end
				MODE_AUTO8: begin
					s.lo = (lo == 8'hff) ? hi : lo + 8'h01;
					s.ovf = (lo == 8'hff);
					s.lo_wrap = (lo == 8'hff);
				end
				default: ; // Stopped: count held
			endcase
		end
		return s;
	endfunction

	// Edge-aligned PWM output update for one channel
	function automatic logic pwm_next(input logic out, input logic adv,
		input logic wrap, input logic [7:0] cnt, input logic [7:0] shadow,
		input logic [7:0] duty);
		if (!adv)
			return out;
		if (wrap)
			return (duty != 8'h00);
		if (cnt == shadow)
			return 1'b0;
		return out;
	endfunction

	// ======================================================================
	// Registers
	// ======================================================================
	logic [7:0]       timer_pwm_and_width_control_reg, mode_reg, ctrl_reg, clkctl_reg;
	logic [TPS_W-1:0] tps_reg, ps_cnt_reg;
	dtp_cnt_s         cnt0_reg, cnt1_reg;
	logic [7:0]       rl0_reg, rh0_reg, rl1_reg, rh1_reg;
	logic [7:0]       shadow0_reg, shadow1_reg;
	logic             pin0_reg, pin1_reg, half_reg;
	logic             pin0_prev_reg, pin1_prev_reg;
	logic             ph_wr_reg, ph_rd_reg;
	logic [7:0]       addr_reg;

	// ======================================================================
	// AHB-Lite slave
	// ======================================================================
	logic       acc, wr_go;
	logic [7:0] wd, rd_val;
	assign acc = hsel && htrans[1] && hready;
	assign wr_go = ph_wr_reg;
	assign wd = hwdata[7:0];
	// Reads take one wait state so that read data comes from a flop
	assign hreadyout = !ph_rd_reg;
	assign hresp = 1'b0;

	// Phase tracking; upper address bits alias, only index bits decode
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ph_wr_reg <= 1'b0;
			ph_rd_reg <= 1'b0;
			addr_reg  <= 8'h00;
		end else begin
			ph_wr_reg <= acc && hwrite;
			ph_rd_reg <= acc && !hwrite;
			if (acc)
				addr_reg <= haddr[9:2];
		end
	end

	// Read mux; unmapped indices read zero
	always_comb begin
		case (addr_reg)
			IDX_TIMER_PWM_AND_WIDTH_CONTROL:  rd_val = timer_pwm_and_width_control_reg;
			IDX_MODE:   rd_val = mode_reg;
			IDX_CTRL:   rd_val = ctrl_reg;
			IDX_TL0:    rd_val = cnt0_reg.lo;
			IDX_TH0:    rd_val = cnt0_reg.hi;
			IDX_TL1:    rd_val = cnt1_reg.lo;
			IDX_TH1:    rd_val = cnt1_reg.hi;
			IDX_RL0:    rd_val = rl0_reg;
			IDX_RH0:    rd_val = rh0_reg;
			IDX_RL1:    rd_val = rl1_reg;
			IDX_RH1:    rd_val = rh1_reg;
			IDX_CLKCTL: rd_val = clkctl_reg;
			IDX_TPS:    rd_val = 8'(tps_reg);
			default:    rd_val = 8'h00;
		endcase
	end

	// Read data captured in the wait cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			hrdata <= 32'h0000_0000;
		else if (ph_rd_reg)
			hrdata <= {24'h00_0000, rd_val};
	end

	// ======================================================================
	// Tick generation
	// ======================================================================
	logic fast, x2_0, x2_1, ps_tick, base0, base1;
	assign fast = clkctl_reg[FAST_BIT];
	assign x2_0 = clkctl_reg[X2_0_BIT];
	assign x2_1 = clkctl_reg[X2_1_BIT];
	assign ps_tick = (ps_cnt_reg == tps_reg);
	// Compatibility mode always divides; half rate doubles the period
	assign base0 = fast ? (x2_0 ? ps_tick : 1'b1)
		: (ps_tick && (!x2_0 || half_reg));
	assign base1 = fast ? (x2_1 ? ps_tick : 1'b1)
		: (ps_tick && (!x2_1 || half_reg));

	// Shared prescaler and its halving toggle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ps_cnt_reg <= '0;
			half_reg   <= 1'b0;
		end else begin
			ps_cnt_reg <= ps_tick ? '0 : ps_cnt_reg + 1'b1;
			if (ps_tick)
				half_reg <= !half_reg;
		end
	end

	// ======================================================================
	// Count enables
	// ======================================================================
	dtp_mode_e md0, md1;
	logic      split, src0, src1, pulse0, pulse1, th0_pulse;
	assign md0 = dtp_mode_e'(mode_reg[M0_LSB +: 2]);
	assign md1 = dtp_mode_e'(mode_reg[M1_LSB +: 2]);
	assign split = (md0 == MODE_SPLIT);
	// Falling edges of the timer pins are taken as count events
	assign src0 = mode_reg[CT0_BIT]
		? (pin0_prev_reg && !timer0_pin_in) : base0;
	assign src1 = mode_reg[CT1_BIT]
		? (pin1_prev_reg && !timer1_pin_in) : base1;
	assign pulse0 = ctrl_reg[TR0_BIT] && src0
		&& (!mode_reg[TIMER0_GATING_ON_BIT] || ext_gate_pin_a);
	// Split mode takes timer 1's run bit away; its mode switches it instead
	assign pulse1 = (split || ctrl_reg[TR1_BIT]) && src1
		&& (!mode_reg[TIMER1_GATING_ON_BIT] || ext_gate_pin_b);
	assign th0_pulse = ctrl_reg[TR1_BIT] && base0;

	// ======================================================================
	// Next counts, flags and PWM levels
	// ======================================================================
	dtp_step_s st0, st1;
	assign st0 = step(cnt0_reg.lo, cnt0_reg.hi, rl0_reg, rh0_reg, md0,
		timer_pwm_and_width_control_reg[T0_WIDTH_SEL_LSB +: 3], timer_pwm_and_width_control_reg[T0_PWM_BIT], pulse0);
	// Timer 1 reload low byte unused outside mode 1; outside split mode the high byte is also the PWM duty in modes 0 and 1
	assign st1 = step(cnt1_reg.lo, cnt1_reg.hi, rl1_reg, rh1_reg, md1,
		timer_pwm_and_width_control_reg[T1_WIDTH_SEL_LSB +: 3], timer_pwm_and_width_control_reg[T1_PWM_BIT], pulse1);

	dtp_cnt_s   nx0;
	logic       set_tf0, set_tf1, lo0_wrap, hi0_wrap;
	logic       pin0_next, pin1_next;
	logic [7:0] sh0_next, sh1_next;

	always_comb begin
		lo0_wrap = pulse0 && (cnt0_reg.lo == 8'hff);
		hi0_wrap = th0_pulse && (cnt0_reg.hi == 8'hff);
		pin0_next = pin0_reg;
		pin1_next = pin1_reg;
		sh0_next = shadow0_reg;
		sh1_next = shadow1_reg;
		if (split) begin
			// Two free 8-bit counters; high half owns timer 1's flag
			nx0.lo = pulse0 ? cnt0_reg.lo + 8'h01 : cnt0_reg.lo;
			nx0.hi = th0_pulse ? cnt0_reg.hi + 8'h01 : cnt0_reg.hi;
			set_tf0 = lo0_wrap;
			set_tf1 = hi0_wrap;
			pin0_next = pwm_next(pin0_reg, pulse0, lo0_wrap, nx0.lo,
				shadow0_reg, rl0_reg);
			pin1_next = pwm_next(pin1_reg, th0_pulse, hi0_wrap, nx0.hi,
				shadow1_reg, rh0_reg);
			if (lo0_wrap)
				sh0_next = rl0_reg;
			if (hi0_wrap)
				sh1_next = rh0_reg;
		end else begin
			nx0.lo = st0.lo;
			nx0.hi = st0.hi;
			set_tf0 = st0.ovf;
			set_tf1 = st1.ovf;
			if (md0 == MODE_AUTO8)
				pin0_next = pin0_reg ^ st0.lo_wrap;
			else
				pin0_next = pwm_next(pin0_reg, st0.hi_adv, st0.hi_wrap,
					st0.hi, shadow0_reg, rh0_reg);
			if (st0.hi_wrap)
				sh0_next = rh0_reg;
		end
		if (!split) begin
			if (md1 == MODE_AUTO8)
				pin1_next = pin1_reg ^ st1.lo_wrap;
			else
				pin1_next = pwm_next(pin1_reg, st1.hi_adv, st1.hi_wrap,
					st1.hi, shadow1_reg, rh1_reg);
			if (st1.hi_wrap)
				sh1_next = rh1_reg;
		end else begin
			set_tf1 = hi0_wrap;
		end
	end

	// ======================================================================
	// Software-visible configuration
	// ======================================================================
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			timer_pwm_and_width_control_reg  <= TIMER_PWM_AND_WIDTH_CONTROL_RST;
			mode_reg   <= ZERO_RST;
			clkctl_reg <= ZERO_RST;
			tps_reg    <= '0;
			rl0_reg    <= ZERO_RST;
			rh0_reg    <= ZERO_RST;
			rl1_reg    <= ZERO_RST;
			rh1_reg    <= ZERO_RST;
		end else if (wr_go) begin
			case (addr_reg)
				IDX_TIMER_PWM_AND_WIDTH_CONTROL:  timer_pwm_and_width_control_reg  <= wd;
				IDX_MODE:   mode_reg   <= wd;
				IDX_CLKCTL: clkctl_reg <= wd;
				IDX_TPS:    tps_reg    <= wd[TPS_W-1:0];
				IDX_RL0:    rl0_reg    <= wd;
				IDX_RH0:    rh0_reg    <= wd;
				IDX_RL1:    rl1_reg    <= wd;
				IDX_RH1:    rh1_reg    <= wd;
				default: ;
			endcase
		end
	end

	// Run and flag bits; a hardware set beats a software clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= ZERO_RST;
		end else begin
			if (wr_go && addr_reg == IDX_CTRL)
				ctrl_reg <= wd;
			if (set_tf0)
				ctrl_reg[TF0_BIT] <= 1'b1;
			if (set_tf1)
				ctrl_reg[TF1_BIT] <= 1'b1;
		end
	end

	// ======================================================================
	// Counters, shadows and pins
	// ======================================================================
	// A bus write to a count wins over counting in that cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt0_reg <= '0;
			cnt1_reg <= '0;
		end else begin
			cnt0_reg.lo <= (wr_go && addr_reg == IDX_TL0) ? wd : nx0.lo;
			cnt0_reg.hi <= (wr_go && addr_reg == IDX_TH0) ? wd : nx0.hi;
			cnt1_reg.lo <= (wr_go && addr_reg == IDX_TL1) ? wd : st1.lo;
			cnt1_reg.hi <= (wr_go && addr_reg == IDX_TH1) ? wd : st1.hi;
		end
	end

	// Compare shadows change only at wrap, so a duty write cannot glitch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shadow0_reg   <= ZERO_RST;
			shadow1_reg   <= ZERO_RST;
			pin0_reg      <= 1'b0;
			pin1_reg      <= 1'b0;
			pin0_prev_reg <= 1'b0;
			pin1_prev_reg <= 1'b0;
		end else begin
			shadow0_reg   <= sh0_next;
			shadow1_reg   <= sh1_next;
			pin0_reg      <= pin0_next;
			pin1_reg      <= pin1_next;
			pin0_prev_reg <= timer0_pin_in;
			pin1_prev_reg <= timer1_pin_in;
		end
	end

	assign timer0_pin_out = pin0_reg;
	assign timer1_pin_out = pin1_reg;
	assign timer0_pin_oe  = timer_pwm_and_width_control_reg[T0_PWM_BIT];
	assign timer1_pin_oe  = timer_pwm_and_width_control_reg[T1_PWM_BIT];

	// ======================================================================
	// Assertions
	// ======================================================================
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	logic [7:0] m0_mask;
	assign m0_mask = 8'hff >> (3'd7 - timer_pwm_and_width_control_reg[T0_WIDTH_SEL_LSB +: 3]);

	pwm_pin_enable_a: assert property (wr_go && addr_reg == IDX_TIMER_PWM_AND_WIDTH_CONTROL
		|=> timer0_pin_oe == $past(wd[T0_PWM_BIT]))
		else $error("pin enable does not follow written bit");
	width_upper_hold_a: assert property (!wr_go && !split
		&& md0 == MODE_VAR_WIDTH |=> (cnt0_reg.lo & ~$past(m0_mask))
		== ($past(cnt0_reg.lo) & ~$past(m0_mask)))
		else $error("inactive prescaler bits changed");
	var_rollover_a: assert property (!wr_go && md0 == MODE_VAR_WIDTH
		&& pulse0 && cnt0_reg.hi == 8'hff
		&& (cnt0_reg.lo & m0_mask) == m0_mask
		|=> ctrl_reg[TF0_BIT] && cnt0_reg.hi == 8'h00)
		else $error("mode 0 rollover missed");
	gate_hold_a: assert property (!wr_go && !pulse0 && !split
		|=> $stable(cnt0_reg))
		else $error("timer 0 counted while disabled");
	auto16_reload_a: assert property (!wr_go && md0 == MODE_AUTO16
		&& !timer_pwm_and_width_control_reg[T0_PWM_BIT] && pulse0 && cnt0_reg == 16'hffff
		|=> ctrl_reg[TF0_BIT] && cnt0_reg == {$past(rh0_reg),
		$past(rl0_reg)})
		else $error("16-bit reload wrong");
	auto8_reload_a: assert property (!wr_go && md0 == MODE_AUTO8
		&& pulse0 && cnt0_reg.lo == 8'hff
		|=> cnt0_reg.lo == $past(cnt0_reg.hi) && $stable(cnt0_reg.hi))
		else $error("8-bit reload wrong");
	t1_stop_hold_a: assert property (!wr_go && md1 == MODE_SPLIT
		|=> $stable(cnt1_reg))
		else $error("timer 1 moved in stop mode");
	fast_rate_a: assert property (!wr_go && fast && !x2_0
		&& md0 == MODE_AUTO8 && ctrl_reg[TR0_BIT] && !mode_reg[TIMER0_GATING_ON_BIT]
		&& !mode_reg[CT0_BIT] && cnt0_reg.lo != 8'hff
		|=> cnt0_reg.lo == $past(cnt0_reg.lo) + 8'h01)
		else $error("fast mode did not count every clock");
	split_no_t1flag_a: assert property (split && !hi0_wrap
		&& !(wr_go && addr_reg == IDX_CTRL) && !ctrl_reg[TF1_BIT]
		|=> !ctrl_reg[TF1_BIT])
		else $error("timer 1 flagged during split mode");
	pwm_wrap_level_a: assert property (!split && md0 == MODE_VAR_WIDTH
		&& st0.hi_wrap |=> timer0_pin_out == ($past(rh0_reg) != 8'h00)
		&& shadow0_reg == $past(rh0_reg))
		else $error("PWM wrap level or shadow wrong");
	pwm_zero_low_a: assert property (!split && md0 != MODE_AUTO8
		&& shadow0_reg == 8'h00 && rh0_reg == 8'h00 && !timer0_pin_out
		|=> !timer0_pin_out)
		else $error("zero duty output went high");

	mode0_overflow_c: cover property (md0 == MODE_VAR_WIDTH && set_tf0);
	pwm_wrap_c: cover property (timer_pwm_and_width_control_reg[T0_PWM_BIT] && st0.hi_wrap
		&& rh0_reg != 8'h00);
	split_both_c: cover property (split && set_tf0 ##[1:600] set_tf1);
	toggle_c: cover property (md1 == MODE_AUTO8 && st1.lo_wrap);

endmodule // dtp_timers

// *** verification/dtp_timers_bench.sv ***
// Self-checking testbench for the dual timer/PWM block
`timescale 1ns/1ps

module dtp_timers_bench import dtp_pkg::*;;

	// ======================================================================
	// Signals
	// ======================================================================
	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] wd;
		logic [7:0] ex;
	} dtp_row_s;

	logic        clk            = 1'b0;
	logic        rstn           = 1'b0;
	logic        hsel           = 1'b0;
	logic [31:0] haddr          = 32'h0;
	logic [1:0]  htrans         = 2'b00;
	logic        hwrite         = 1'b0;
	logic [31:0] hwdata         = 32'h0;
	logic        ext_gate_pin_a = 1'b0;
	logic        ext_gate_pin_b = 1'b1;
	logic        timer0_pin_in  = 1'b0;
	logic        timer1_pin_in  = 1'b0;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        timer0_pin_out;
	logic        timer0_pin_oe;
	logic        timer1_pin_out;
	logic        timer1_pin_oe;
	int          bad_count      = 0;
	int          cmp_count      = 0;
	int          highs;

	// Ordinary cases: write, then read back; 7f is an unmapped index
	dtp_row_s rows [7] = '{
		'{IDX_TIMER_PWM_AND_WIDTH_CONTROL,  8'h3f, 8'h3f}, '{IDX_RL1, 8'ha5, 8'ha5},
		'{IDX_RH1,    8'h5a, 8'h5a}, '{IDX_RL0, 8'h3c, 8'h3c},
		'{IDX_RH0,    8'hc3, 8'hc3}, '{8'h7f,   8'hff, 8'h00},
		'{IDX_CLKCTL, 8'h80, 8'h80}};

	// Single slave: its ready output is the bus ready
	dtp_timers #(.TPS_W(4)) dtp_timers_inst (
		.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .ext_gate_pin_a(ext_gate_pin_a),
		.ext_gate_pin_b(ext_gate_pin_b), .timer0_pin_in(timer0_pin_in),
		.timer0_pin_out(timer0_pin_out), .timer0_pin_oe(timer0_pin_oe),
		.timer1_pin_in(timer1_pin_in), .timer1_pin_out(timer1_pin_out),
		.timer1_pin_oe(timer1_pin_oe));

	// Clock, 20 ns period
	always #10 clk = ~clk;

	// ======================================================================
	// Tasks
	// ======================================================================
	task automatic check8(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Bounded wait so a stuck ready shows as a mismatch, not a hang
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 16);
		if (n >= 16) check8("hready wait", 8'h01, 8'h00);
	endtask

	// One single AHB transfer; read data is taken at the closing edge
	task automatic bus(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd, output logic [7:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'b00};
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		wait_ready();
		rd = hrdata[7:0];
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [7:0] junk;
		bus(1'b1, idx, wd, junk);
	endtask

	task automatic rdm(input string name, input logic [7:0] idx,
		input logic [7:0] mask, input logic [7:0] exp);
		logic [7:0] rd;
		bus(1'b0, idx, 8'h00, rd);
		check8(name, exp, rd & mask);
	endtask

	// Samples mid-cycle, where the pin level has settled
	task automatic count_high(input int cycles, output int n);
		n = 0;
		repeat (cycles) begin
			@(negedge clk);
			if (timer0_pin_out === 1'b1) n++;
		end
	endtask

	// Counts level changes of the timer 1 pin between mid-cycle samples
	task automatic count_toggles(input int cycles, output int n);
		logic last;
		n = 0;
		@(negedge clk);
		last = timer1_pin_out;
		repeat (cycles) begin
			@(negedge clk);
			if (timer1_pin_out !== last) n++;
			last = timer1_pin_out;
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ======================================================================
	// Watchdog: the full run needs a few thousand cycles
	// ======================================================================
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		print_verdict();
	end

	// ======================================================================
	// Main sequence
	// ======================================================================
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		check8("pin oe at reset", 8'h00, {7'h0, timer0_pin_oe});
		// Reset value, then write and read back, for every row
		foreach (rows[i]) begin
			rdm("reset value", rows[i].idx, 8'hff,
				(rows[i].idx == IDX_TIMER_PWM_AND_WIDTH_CONTROL) ? TIMER_PWM_AND_WIDTH_CONTROL_RST : ZERO_RST);
			wr(rows[i].idx, rows[i].wd);
			rdm("readback", rows[i].idx, 8'hff, rows[i].ex);
		end
		check8("okay response", 8'h00, {7'h0, hresp});
		// Mode 0 with 5 prescale bits: overflows within a few ticks
		wr(IDX_TIMER_PWM_AND_WIDTH_CONTROL, 8'h24);
		wr(IDX_TH0, 8'hff);
		wr(IDX_TL0, 8'h1c);
		wr(IDX_CTRL, 8'h10);
		repeat (20) @(posedge clk);
		rdm("mode0 flag", IDX_CTRL, 8'h30, 8'h30);
		rdm("mode0 high wrap", IDX_TH0, 8'hff, 8'h00);
		wr(IDX_CTRL, 8'h00);
		// Mode 1: wrap reloads from the reload pair
		wr(IDX_TH0, 8'hff);
		wr(IDX_TL0, 8'hfc);
		wr(IDX_RL0, 8'h34);
		wr(IDX_RH0, 8'h12);
		wr(IDX_MODE, 8'h01);
		wr(IDX_CTRL, 8'h10);
		repeat (20) @(posedge clk);
		rdm("mode1 reload", IDX_TH0, 8'hff, 8'h12);
		rdm("mode1 flag", IDX_CTRL, 8'h30, 8'h30);
		wr(IDX_CTRL, 8'h00);
		// Mode 2 on both timers: low reloads from high, high untouched
		wr(IDX_TH1, 8'hf0);
		wr(IDX_TL1, 8'hfc);
		wr(IDX_TH0, 8'hf8);
		wr(IDX_TL0, 8'hfc);
		wr(IDX_MODE, 8'h22);
		wr(IDX_CTRL, 8'h50);
		repeat (20) @(posedge clk);
		// Reload every 16 clocks, so any 64-clock window holds 4 toggles
		count_toggles(64, highs);
		check8("mode2 t1 toggles", 8'h04, highs[7:0]);
		rdm("mode2 high kept", IDX_TH1, 8'hff, 8'hf0);
		rdm("mode2 t0 high kept", IDX_TH0, 8'hff, 8'hf8);
		rdm("mode2 low range", IDX_TL1, 8'hf0, 8'hf0);
		rdm("mode2 flag", IDX_CTRL, 8'hc0, 8'hc0);
		// Timer 1 in its own mode 3 holds although run is set
		// Mode first: timer 1 is still counting in mode 2 until then
		wr(IDX_MODE, 8'h30);
		wr(IDX_TL1, 8'h55);
		repeat (10) @(posedge clk);
		rdm("mode3 hold", IDX_TL1, 8'hff, 8'h55);
		wr(IDX_CTRL, 8'h00);
		// Gate closed by a low pin, then opened
		wr(IDX_TL0, 8'h00);
		wr(IDX_MODE, 8'h09);
		wr(IDX_CTRL, 8'h10);
		repeat (10) @(posedge clk);
		rdm("gate closed", IDX_TL0, 8'hff, 8'h00);
		ext_gate_pin_a <= 1'b1;
		repeat (20) @(posedge clk);
		rdm("gate open", IDX_TL0, 8'hf0, 8'h10);
		wr(IDX_CTRL, 8'h00);
		// Counter source: five falling edges on the pin
		wr(IDX_MODE, 8'h05);
		wr(IDX_TL0, 8'h00);
		wr(IDX_CTRL, 8'h10);
		repeat (5) begin
			repeat (2) @(posedge clk);
			timer0_pin_in <= 1'b1;
			repeat (2) @(posedge clk);
			timer0_pin_in <= 1'b0;
		end
		repeat (4) @(posedge clk);
		rdm("pin edges", IDX_TL0, 8'hff, 8'h05);
		wr(IDX_CTRL, 8'h00);
		// Split mode: timer 1 runs on its own, without run bit or flag
		wr(IDX_TH1, 8'hff);
		wr(IDX_TL1, 8'hfc);
		wr(IDX_TH0, 8'hfe);
		wr(IDX_TL0, 8'hfc);
		wr(IDX_MODE, 8'h13);
		wr(IDX_CTRL, 8'h10);
		repeat (20) @(posedge clk);
		rdm("split t1 no flag", IDX_CTRL, 8'hf0, 8'h30);
		rdm("split t1 reload", IDX_TH1, 8'hff, 8'h5a);
		// High half counts on timer 1's run bit and owns its flag
		wr(IDX_CTRL, 8'h40);
		repeat (20) @(posedge clk);
		rdm("split high flag", IDX_CTRL, 8'hc0, 8'hc0);
		wr(IDX_CTRL, 8'h00);
		// Compatibility mode, half rate, prescale 4: a tick per 8 clocks
		wr(IDX_CLKCTL, 8'h01);
		wr(IDX_TPS, 8'h03);
		wr(IDX_MODE, 8'h01);
		wr(IDX_TL0, 8'h00);
		wr(IDX_CTRL, 8'h10);
		repeat (40) @(posedge clk);
		// About 42 clocks give 5 or 6 ticks; a lost halving gives 10
		rdm("half rate count", IDX_TL0, 8'hf8, 8'h00);
		wr(IDX_CTRL, 8'h00);
		wr(IDX_CLKCTL, 8'h80);
		wr(IDX_TPS, 8'h00);
		// PWM mode 1, one high-count step per clock: period 256
		wr(IDX_MODE, 8'h01);
		wr(IDX_TIMER_PWM_AND_WIDTH_CONTROL, 8'h64);
		wr(IDX_RH0, 8'h00);
		wr(IDX_RL0, 8'hff);
		wr(IDX_TH0, 8'h00);
		wr(IDX_TL0, 8'hff);
		wr(IDX_CTRL, 8'h10);
		check8("pwm pin oe", 8'h01, {7'h0, timer0_pin_oe});
		check8("t1 pin oe", 8'h00, {7'h0, timer1_pin_oe});
		// Pin level before the first wrap is left over from earlier modes
		repeat (300) @(posedge clk);
		count_high(600, highs);
		check8("duty zero highs", 8'h00,
			(highs > 255) ? 8'hff : highs[7:0]);
		// New duty reaches the shadow only at a wrap
		wr(IDX_RH0, 8'h80);
		repeat (300) @(posedge clk);
		count_high(256, highs);
		check8("duty half highs", 8'h80, highs[7:0]);
		wr(IDX_TIMER_PWM_AND_WIDTH_CONTROL, 8'h24);
		@(negedge clk);
		check8("pin oe off", 8'h00, {7'h0, timer0_pin_oe});
		print_verdict();
	end

endmodule // dtp_timers_bench
